// File: cmp1_pkg.sv
// Package with register offsets, field positions and reset values for comparator one
package cmp1_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] CMP1_CONTROL_ADDR = 8'h9A;
  localparam logic [7:0] CMP1_MODE_ADDR = 8'h9C;

  // ****************************************************
  // Control register fields
  // ****************************************************
  localparam int CMP1_ON_BIT = 7;
  localparam int CMP1_RESULT_BIT = 6;
  localparam int CMP1_RISE_FLAG_BIT = 5;
  localparam int CMP1_FALL_FLAG_BIT = 4;
  localparam int CMP1_UHYS_HI = 3;
  localparam int CMP1_UHYS_LO = 2;
  localparam int CMP1_LHYS_HI = 1;
  localparam int CMP1_LHYS_LO = 0;
  localparam logic [7:0] CMP1_CONTROL_RESET = 8'h00;

  // ****************************************************
  // Mode register fields
  // ****************************************************
  localparam int CMP1_RSVD_BIT = 7;
  localparam int CMP1_RISE_IE_BIT = 5;
  localparam int CMP1_FALL_IE_BIT = 4;
  localparam int CMP1_SPEED_HI = 1;
  localparam int CMP1_SPEED_LO = 0;
  localparam logic [7:0] CMP1_MODE_RESET = 8'h82;
  localparam logic [1:0] CMP1_SPEED_RESET = 2'h2;

  // Hysteresis codes: off, 5 mV, 10 mV, 20 mV
  typedef enum logic [1:0] {
    CMP1_HYS_OFF = 2'h0,
    CMP1_HYS_5MV = 2'h1,
    CMP1_HYS_10MV = 2'h2,
    CMP1_HYS_20MV = 2'h3
  } cmp1_hys_t;

  // Response modes: 0 fastest/highest power .. 3 slowest/lowest power
  typedef enum logic [1:0] {
    CMP1_MODE_FAST = 2'h0,
    CMP1_MODE_1 = 2'h1,
    CMP1_MODE_2 = 2'h2,
    CMP1_MODE_SLOW = 2'h3
  } cmp1_speed_t;
endpackage

// File: cmp1_sync.sv
// Two-flop synchroniser with edge detection for the comparator output
`timescale 1ns/1ps
`default_nettype none
module cmp1_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Asynchronous analog result
  input wire logic async_in,
  // Synchronised level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  // ****************************************************
  // Next-state logic
  // ****************************************************
  // Edge detection looks only at the second and third stages, never the first
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // Registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // Compare current sample with previous one
  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

// File: cmp1_regs.sv
// Control and mode registers of comparator one on the special function register bus
//
// Summary of operation
// - Control bit 7 switches comparator on
// - Control bit 6 reads comparator result
// - Rising edge sets sticky flag, software clears
// - Falling edge sets sticky flag, software clears
// - Control bits 3:2 select upper hysteresis
// - Control bits 1:0 select lower hysteresis
// - Mode bit 7 reads one always
// - Mode bits 6, 3:2 read zero
// - Mode bit 5 enables rising interrupt
// - Mode bit 4 enables falling interrupt
// - Mode bits 1:0 select response speed
// - Disabled comparator held in low power
`timescale 1ns/1ps
`default_nettype none
module cmp1_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Special function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Analog comparator front end
  input wire logic comparator_raw,
  output logic comparator_on,
  output logic comparator_low_power,
  output logic [1:0] upper_hysteresis_select,
  output logic [1:0] lower_hysteresis_select,
  output logic [1:0] response_speed_select,
  // Interrupt request to the core
  output logic comparator_irq
);
  // Synchronised comparator result and its one-cycle edge pulses
  logic result_level;
  logic rise_pulse;
  logic fall_pulse;

  // Register state and next values, one pair per field
  logic on_reg;
  logic on_next;
  logic rise_flag_reg;
  logic rise_flag_next;
  logic fall_flag_reg;
  logic fall_flag_next;
  logic [1:0] uhys_reg;
  logic [1:0] uhys_next;
  logic [1:0] lhys_reg;
  logic [1:0] lhys_next;
  logic rise_ie_reg;
  logic rise_ie_next;
  logic fall_ie_reg;
  logic fall_ie_next;
  logic [1:0] speed_reg;
  logic [1:0] speed_next;
  logic irq_reg;
  logic irq_next;
  logic lowp_reg;
  logic lowp_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Decoded write strobes and the two read views
  logic wr_ctrl;
  logic wr_mode;
  logic [7:0] ctrl_view;
  logic [7:0] mode_view;

  // ****************************************************
  // Result synchroniser and edge detector
  // ****************************************************
  // Two flops guard against metastability at the cost of two cycles of latency
  // Pulses shorter than one clock may be missed entirely
  cmp1_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(comparator_raw),
    .level(result_level),
    .rise(rise_pulse),
    .fall(fall_pulse)
  );

  // ****************************************************
  // Address decode
  // ****************************************************
  // Write strobes per register
  // Unmapped addresses give no strobe, so such writes are dropped
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mode = 1'b0;
    if (sfr_wr && sfr_addr == cmp1_pkg::CMP1_CONTROL_ADDR) begin
      wr_ctrl = 1'b1;
    end else if (sfr_wr && sfr_addr == cmp1_pkg::CMP1_MODE_ADDR) begin
      wr_mode = 1'b1;
    end
  end

  // Read views; reserved bit fixed at one, unused bits zero
  // Result bit comes straight from the synchroniser and is never stored
  always_comb begin
    ctrl_view = {on_reg, result_level, rise_flag_reg, fall_flag_reg,
                 uhys_reg, lhys_reg};
    mode_view = 8'h00;
    mode_view[cmp1_pkg::CMP1_RSVD_BIT] = 1'b1;
    mode_view[cmp1_pkg::CMP1_RISE_IE_BIT] = rise_ie_reg;
    mode_view[cmp1_pkg::CMP1_FALL_IE_BIT] = fall_ie_reg;
    mode_view[cmp1_pkg::CMP1_SPEED_HI:cmp1_pkg::CMP1_SPEED_LO] = speed_reg;
  end

  // ****************************************************
  // Register next values
  // ****************************************************
  // Flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    on_next = on_reg;
    uhys_next = uhys_reg;
    lhys_next = lhys_reg;
    rise_ie_next = rise_ie_reg;
    fall_ie_next = fall_ie_reg;
    speed_next = speed_reg;
    rise_flag_next = rise_flag_reg;
    fall_flag_next = fall_flag_reg;
    // Control writes; the result position is read-only and never stored
    // Writing one to a flag sets it, as a plain read-write bit would
    if (wr_ctrl) begin
      on_next = sfr_wdata[cmp1_pkg::CMP1_ON_BIT];
      rise_flag_next = sfr_wdata[cmp1_pkg::CMP1_RISE_FLAG_BIT];
      fall_flag_next = sfr_wdata[cmp1_pkg::CMP1_FALL_FLAG_BIT];
      uhys_next = sfr_wdata[cmp1_pkg::CMP1_UHYS_HI:cmp1_pkg::CMP1_UHYS_LO];
      lhys_next = sfr_wdata[cmp1_pkg::CMP1_LHYS_HI:cmp1_pkg::CMP1_LHYS_LO];
    end
    // Mode writes; reserved and unused positions are dropped here
    if (wr_mode) begin
      rise_ie_next = sfr_wdata[cmp1_pkg::CMP1_RISE_IE_BIT];
      fall_ie_next = sfr_wdata[cmp1_pkg::CMP1_FALL_IE_BIT];
      speed_next = sfr_wdata[cmp1_pkg::CMP1_SPEED_HI:cmp1_pkg::CMP1_SPEED_LO];
    end
    // Edges only counted while the comparator is on, its output is meaningless off
    // A clear in the same cycle as an edge loses, so no edge goes unseen
    if (rise_pulse && on_reg) begin
      rise_flag_next = 1'b1;
    end
    if (fall_pulse && on_reg) begin
      fall_flag_next = 1'b1;
    end
  end

  // Outputs computed from next values so they leave flip-flops aligned
  // Interrupt rises on the same edge as the flag that causes it
  // Read data is zero when nothing is addressed, so stale data never lingers
  always_comb begin
    irq_next = (rise_flag_next & rise_ie_next) | (fall_flag_next & fall_ie_next);
    lowp_next = ~on_next;
    rdata_next = 8'h00;
    if (sfr_rd && sfr_addr == cmp1_pkg::CMP1_CONTROL_ADDR) begin
      rdata_next = ctrl_view;
    end else if (sfr_rd && sfr_addr == cmp1_pkg::CMP1_MODE_ADDR) begin
      rdata_next = mode_view;
    end
  end

  // ****************************************************
  // State registers
  // ****************************************************
  // Control register; flags start clear so no stale edge survives a reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      on_reg <= cmp1_pkg::CMP1_CONTROL_RESET[cmp1_pkg::CMP1_ON_BIT];
      rise_flag_reg <= cmp1_pkg::CMP1_CONTROL_RESET[cmp1_pkg::CMP1_RISE_FLAG_BIT];
      fall_flag_reg <= cmp1_pkg::CMP1_CONTROL_RESET[cmp1_pkg::CMP1_FALL_FLAG_BIT];
      uhys_reg <= cmp1_pkg::CMP1_CONTROL_RESET[cmp1_pkg::CMP1_UHYS_HI:cmp1_pkg::CMP1_UHYS_LO];
      lhys_reg <= cmp1_pkg::CMP1_CONTROL_RESET[cmp1_pkg::CMP1_LHYS_HI:cmp1_pkg::CMP1_LHYS_LO];
    end else begin
      on_reg <= on_next;
      rise_flag_reg <= rise_flag_next;
      fall_flag_reg <= fall_flag_next;
      uhys_reg <= uhys_next;
      lhys_reg <= lhys_next;
    end
  end

  // Mode register; interrupt enables start off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rise_ie_reg <= cmp1_pkg::CMP1_MODE_RESET[cmp1_pkg::CMP1_RISE_IE_BIT];
      fall_ie_reg <= cmp1_pkg::CMP1_MODE_RESET[cmp1_pkg::CMP1_FALL_IE_BIT];
      speed_reg <= cmp1_pkg::CMP1_SPEED_RESET;
    end else begin
      rise_ie_reg <= rise_ie_next;
      fall_ie_reg <= fall_ie_next;
      speed_reg <= speed_next;
    end
  end

  // Output flops; low power starts asserted because the comparator starts off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
      lowp_reg <= ~cmp1_pkg::CMP1_CONTROL_RESET[cmp1_pkg::CMP1_ON_BIT];
      rdata_reg <= 8'h00;
    end else begin
      irq_reg <= irq_next;
      lowp_reg <= lowp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  // Hysteresis and speed reach the analog side unchanged, no re-timing needed
  assign comparator_on = on_reg;
  assign comparator_low_power = lowp_reg;
  assign upper_hysteresis_select = uhys_reg;
  assign lower_hysteresis_select = lhys_reg;
  assign response_speed_select = speed_reg;
  assign comparator_irq = irq_reg;
  assign sfr_rdata = rdata_reg;
endmodule
`default_nettype wire

// File: cmp1_front.sv
// Behavioural analog front end of comparator one, driving the raw result
`timescale 1ns/1ps
`default_nettype none
module cmp1_front (
  // Clock and enable from the block
  input wire logic sys_clk,
  input wire logic comparator_on,
  // Test-set relation of the two input voltages
  input wire logic plus_above,
  // Raw comparator output
  output logic comparator_raw
);
  // ****************************************************
  // Output stage
  // ****************************************************
  initial comparator_raw = 1'b0;
  // Powered down output is meaningless, so it wanders instead of holding
  always @(posedge sys_clk) begin
    comparator_raw <= comparator_on ? plus_above : ~comparator_raw;
  end
endmodule
`default_nettype wire

// File: cmp1_regs_checker.sv
// Port-level assertions for the comparator one register bank
`timescale 1ns/1ps
`default_nettype none
module cmp1_regs_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Comparator side
  input wire logic comparator_raw,
  input wire logic comparator_on,
  input wire logic comparator_low_power,
  input wire logic [1:0] upper_hysteresis_select,
  input wire logic [1:0] lower_hysteresis_select,
  input wire logic [1:0] response_speed_select,
  input wire logic comparator_irq
);
  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  localparam logic [7:0] CTL = cmp1_pkg::CMP1_CONTROL_ADDR;
  localparam logic [7:0] MOD = cmp1_pkg::CMP1_MODE_ADDR;
  logic wc;
  logic wm;
  // Write strobes per register, decoded from the bus as the core drives it
  assign wc = sfr_wr && sfr_addr == CTL;
  assign wm = sfr_wr && sfr_addr == MOD;
  AST_ON: assert property (wc |=> comparator_on == $past(sfr_wdata[7]))
    else $error("enable bit not taken");
  AST_LOWPWR: assert property (comparator_low_power == !comparator_on)
    else $error("low power not tied to enable");
  AST_UHYS: assert property (wc |=> upper_hysteresis_select == $past(sfr_wdata[3:2]))
    else $error("upper hysteresis wrong");
  AST_LHYS: assert property (wc |=> lower_hysteresis_select == $past(sfr_wdata[1:0]))
    else $error("lower hysteresis wrong");
  AST_SPEED: assert property (wm |=> response_speed_select == $past(sfr_wdata[1:0]))
    else $error("speed select wrong");
  AST_MODE_FIXED: assert property (sfr_rd && sfr_addr == MOD
      |=> sfr_rdata[7] && sfr_rdata[6] == 1'b0 && sfr_rdata[3:2] == 2'h0)
    else $error("mode fixed bits wrong");
  AST_RD_ON: assert property (sfr_rd && !sfr_wr && sfr_addr == CTL
      |=> sfr_rdata[7] == comparator_on)
    else $error("enable readback wrong");
  AST_IRQ_HOLD: assert property (comparator_irq && !sfr_wr |=> comparator_irq)
    else $error("irq dropped without a write");
  AST_OFF_QUIET: assert property (!comparator_on && !comparator_irq && !sfr_wr
      |=> !comparator_irq)
    else $error("edge flagged while disabled");
endmodule
bind cmp1_regs cmp1_regs_checker u_chk (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata),
  .comparator_raw(comparator_raw),
  .comparator_on(comparator_on),
  .comparator_low_power(comparator_low_power),
  .upper_hysteresis_select(upper_hysteresis_select),
  .lower_hysteresis_select(lower_hysteresis_select),
  .response_speed_select(response_speed_select),
  .comparator_irq(comparator_irq)
);
`default_nettype wire

// File: cmp1_regs_tb.sv
// Self-checking testbench for the comparator one register bank
`timescale 1ns/1ps
`default_nettype none
module cmp1_regs_tb;
  localparam logic [7:0] CTL = cmp1_pkg::CMP1_CONTROL_ADDR;
  localparam logic [7:0] MOD = cmp1_pkg::CMP1_MODE_ADDR;
  logic sys_clk, resetn, sfr_wr, sfr_rd, comparator_raw, plus_above, rd_taken;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, mon_e, mon_m;
  logic comparator_on, comparator_low_power, comparator_irq;
  logic [1:0] upper_hysteresis_select, lower_hysteresis_select, response_speed_select, rnd;
  logic [7:0] exp_q[$];
  logic [7:0] mask_q[$];
  int n_errors = 0;
  int n_checks = 0;
  int seed = 84;
  cmp1_regs dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata),
    .comparator_raw(comparator_raw),
    .comparator_on(comparator_on),
    .comparator_low_power(comparator_low_power),
    .upper_hysteresis_select(upper_hysteresis_select),
    .lower_hysteresis_select(lower_hysteresis_select),
    .response_speed_select(response_speed_select),
    .comparator_irq(comparator_irq)
  );
  cmp1_front u_front (.sys_clk(sys_clk), .comparator_on(comparator_on),
    .plus_above(plus_above), .comparator_raw(comparator_raw));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  // Expected read data is queued here, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
  endtask
  // Read data monitor; bit 6 is masked while the front end is off
  always @(posedge sys_clk) rd_taken <= sfr_rd;
  always @(negedge sys_clk) begin
    if (rd_taken === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      mon_m = mask_q.pop_front();
      check("sfr_rdata", mon_e & mon_m, sfr_rdata & mon_m);
    end
  end
  // Watchdog, generous against roughly 100 cycles of tests
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    resetn = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    plus_above = 1'b0;
    rnd = 2'($random(seed));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(CTL, 8'h00, 8'hBF);
    rd(MOD, 8'h82);
    // Every hysteresis and speed code; reserved mode bits written high
    for (int i = 0; i < 4; i++) begin
      wr(MOD, 8'hCC | {6'h00, 2'(i) ^ rnd});
      wr(CTL, {4'h0, 2'(i), ~2'(i)});
      @(negedge sys_clk);
      check("speed", {6'h00, 2'(i) ^ rnd}, {6'h00, response_speed_select});
      check("upper", 8'(i), {6'h00, upper_hysteresis_select});
      check("lower", 8'(3 - i), {6'h00, lower_hysteresis_select});
      rd(MOD, 8'h80 | {6'h00, 2'(i) ^ rnd});
      rd(CTL, {4'h0, 2'(i), ~2'(i)}, 8'hBF);
    end
    $display("test config done");
    wr(MOD, 8'hB0);
    wr(CTL, 8'h80);
    @(negedge sys_clk);
    check("low_power", 8'h00, {7'h00, comparator_low_power});
    check("on", 8'h01, {7'h00, comparator_on});
    repeat (6) @(posedge sys_clk);
    wr(CTL, 8'h80);
    plus_above <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(CTL, 8'hE0);
    @(negedge sys_clk);
    check("irq", 8'h01, {7'h00, comparator_irq});
    wr(CTL, 8'h80);
    @(negedge sys_clk);
    check("irq", 8'h00, {7'h00, comparator_irq});
    plus_above <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(CTL, 8'h90);
    @(negedge sys_clk);
    check("irq", 8'h01, {7'h00, comparator_irq});
    wr(MOD, 8'hA0);
    @(negedge sys_clk);
    check("irq", 8'h00, {7'h00, comparator_irq});
    wr(CTL, 8'h80);
    plus_above <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wr(CTL, 8'h20);
    @(negedge sys_clk);
    check("irq", 8'h01, {7'h00, comparator_irq});
    check("low_power", 8'h01, {7'h00, comparator_low_power});
    wr(CTL, 8'h00);
    repeat (8) @(posedge sys_clk);
    rd(CTL, 8'h00, 8'hBF);
    $display("test edges done");
    wr(8'h9B, 8'hFF);
    rd(8'h9B, 8'h00);
    rd(MOD, 8'hA0);
    rd(CTL, 8'h00, 8'hBF);
    $display("test unmapped done");
    repeat (3) @(posedge sys_clk);
    give_verdict();
  end
endmodule
`default_nettype wire
